// File: logic/oscr_top.sv
//
// Contract
// R1 - Power-save bit halts acquisition until cleared
// R2 - Power-save keeps registers, bus stays served
// R3 - Power-save forces pending interrupts cleared
// R4 - Soft reset restores registers, bit self-clears
// R5 - Soft reset raises no power-good event
// R6 - Mode codes 010 HR, 011 oximetry, 111 multi
// R7 - Mode change leaves other settings untouched
// R8 - ADC range doubles full scale from 2048nA
// R9 - Rate codes select 50 to 3200 samples/s
// R10 - Too-fast rate stored as highest allowed
// R11 - Pulse width sets width and resolution
// R12 - Per-LED amplitude, 0.2 mA per code
// R13 - Multi-LED sample has four slot fields
// R14 - Slot codes: off, red, IR, dark
// R15 - Three bytes per active slot per sample
// R16 - Host enables slots contiguously from first
// R17 - Temperature whole part signed, 1 C/count
// R18 - Fraction unsigned, 0.0625 C steps, added
// R19 - Host sums whole and fraction reads
// R20 - Trigger starts one conversion, self-clears
// R21 - Heart-rate mode pulses red LED only
// R22 - Unassigned bits read zero, ignore writes
`timescale 1ns/1ps
module oscr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic temp_valid,
  input wire logic [7:0] temp_whole_in,
  input wire logic [3:0] temp_part_in,
  output logic temp_start,
  output logic acquire_en,
  output logic irq_clear,
  output logic power_good_event,
  output logic [2:0] active_mode,
  output logic [1:0] adc_range_sel,
  output logic [14:0] adc_full_scale_na,
  output logic [2:0] sample_rate_sel,
  output logic [11:0] sample_rate_sps,
  output logic [1:0] pulse_width_sel,
  output logic [18:0] pulse_width_ns,
  output logic [4:0] adc_resolution,
  output logic [7:0] red_amplitude,
  output logic [7:0] ir_amplitude,
  output logic [15:0] red_current_ua,
  output logic [15:0] ir_current_ua,
  output logic [3:0] slot_red_mask,
  output logic [3:0] slot_ir_mask,
  output logic [3:0] slot_active_mask,
  output logic [3:0] sample_bytes
);

  typedef struct packed {
    logic power_save_bit;
    logic soft_rst;
    logic [2:0] mode;
    logic [1:0] adc_range_sel;
    logic [2:0] sample_rate_sel;
    logic [1:0] pulse_width_sel;
    logic [7:0] red_amplitude;
    logic [7:0] ir_amplitude;
    logic [3:0][2:0] time_slot_sel;
    logic [7:0] temp_whole;
    logic [3:0] temp_part;
    logic temp_busy;
    logic por_pending;
    logic acquire_en;
    logic irq_clear;
    logic power_good_event;
    logic temp_start;
    logic [3:0] red_mask;
    logic [3:0] ir_mask;
    logic [3:0] active_mask;
    logic [3:0] sample_bytes;
    logic [14:0] full_scale;
    logic [11:0] rate_sps;
    logic [18:0] pw_ns;
    logic [4:0] res_bits;
    logic [15:0] red_ua;
    logic [15:0] ir_ua;
  } oscr_state_t;

  oscr_state_t s;
  oscr_state_t next_s;
  oscr_reg_if bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Serial bus front end

  oscr_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register read-back

  // Reads never disturb state, so power-save needs no special case here
  always_comb begin
    bus.rdata = oscr_pkg::REG_RESET; // R22
    if (bus.addr == oscr_pkg::ADDR_MODE) begin
      bus.rdata[oscr_pkg::POWER_SAVE_BIT] = s.power_save_bit;
      bus.rdata[oscr_pkg::SOFT_RST_BIT] = s.soft_rst;
      bus.rdata[oscr_pkg::MODE_LSB +: 3] = s.mode;
    end else if (bus.addr == oscr_pkg::ADDR_ACQ) begin
      bus.rdata[oscr_pkg::ADC_RANGE_LSB +: 2] = s.adc_range_sel;
      bus.rdata[oscr_pkg::RATE_LSB +: 3] = s.sample_rate_sel;
      bus.rdata[oscr_pkg::PW_LSB +: 2] = s.pulse_width_sel;
    end else if (bus.addr == oscr_pkg::ADDR_RED_AMP) begin
      bus.rdata = s.red_amplitude;
    end else if (bus.addr == oscr_pkg::ADDR_IR_AMP) begin
      bus.rdata = s.ir_amplitude;
    end else if (bus.addr == oscr_pkg::ADDR_SLOT_LO) begin
      bus.rdata[oscr_pkg::SLOT_ODD_LSB +: 3] = s.time_slot_sel[0];
      bus.rdata[oscr_pkg::SLOT_EVEN_LSB +: 3] = s.time_slot_sel[1];
    end else if (bus.addr == oscr_pkg::ADDR_SLOT_HI) begin
      bus.rdata[oscr_pkg::SLOT_ODD_LSB +: 3] = s.time_slot_sel[2];
      bus.rdata[oscr_pkg::SLOT_EVEN_LSB +: 3] = s.time_slot_sel[3];
    end else if (bus.addr == oscr_pkg::ADDR_TEMP_WHOLE) begin
      bus.rdata = s.temp_whole; // R17
    end else if (bus.addr == oscr_pkg::ADDR_TEMP_PART) begin
      bus.rdata[3:0] = s.temp_part; // R18
    end else if (bus.addr == oscr_pkg::ADDR_TEMP_TRIG) begin
      bus.rdata[oscr_pkg::TEMP_TRIG_BIT] = s.temp_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register update and derived controls

  always_comb begin
    logic [2:0] ceil_code;
    logic [2:0] want_rate;
    logic [1:0] want_pw;
    logic [3:0] n_active;
    ceil_code = oscr_pkg::RATE_3200;
    want_rate = oscr_pkg::RATE_3200;
    want_pw = 2'h0;
    n_active = 4'h0;
    next_s = s;
    next_s.power_good_event = 1'b0;
    next_s.temp_start = 1'b0;

    // Only a true reset leaves por_pending set
    if (s.por_pending) begin
      next_s.por_pending = 1'b0;
      next_s.power_good_event = 1'b1;
    end

    // Conversion result lands in the data registers and ends the busy flag
    if (s.temp_busy && temp_valid) begin
      next_s.temp_whole = temp_whole_in; // R17
      next_s.temp_part = temp_part_in; // R18
      next_s.temp_busy = 1'b0; // R20
    end

    if (s.soft_rst) begin
      // Register contents go back to power-on values; por_pending is left alone
      next_s.soft_rst = 1'b0; // R4
      next_s.power_save_bit = 1'b0; // R4
      next_s.mode = 3'h0; // R4
      next_s.adc_range_sel = 2'h0; // R4
      next_s.sample_rate_sel = 3'h0; // R4
      next_s.pulse_width_sel = 2'h0; // R4
      next_s.red_amplitude = oscr_pkg::REG_RESET; // R4
      next_s.ir_amplitude = oscr_pkg::REG_RESET; // R4
      next_s.time_slot_sel = '0; // R4
      next_s.temp_whole = oscr_pkg::REG_RESET; // R4
      next_s.temp_part = 4'h0; // R4
      next_s.temp_busy = 1'b0; // R4 R5
    end else if (bus.wr_stb) begin
      // Writes are honoured in power-save too
      if (bus.addr == oscr_pkg::ADDR_MODE) begin
        next_s.power_save_bit = bus.wdata[oscr_pkg::POWER_SAVE_BIT]; // R1 R2
        next_s.soft_rst = bus.wdata[oscr_pkg::SOFT_RST_BIT]; // R4
        next_s.mode = bus.wdata[oscr_pkg::MODE_LSB +: 3]; // R7
      end else if (bus.addr == oscr_pkg::ADDR_ACQ) begin
        want_rate = bus.wdata[oscr_pkg::RATE_LSB +: 3];
        want_pw = bus.wdata[oscr_pkg::PW_LSB +: 2];
        ceil_code = oscr_pkg::rate_ceiling(s.mode, want_pw);
        next_s.adc_range_sel = bus.wdata[oscr_pkg::ADC_RANGE_LSB +: 2]; // R8
        next_s.pulse_width_sel = want_pw; // R11
        next_s.sample_rate_sel = (want_rate > ceil_code) ? ceil_code : want_rate; // R10
      end else if (bus.addr == oscr_pkg::ADDR_RED_AMP) begin
        next_s.red_amplitude = bus.wdata; // R12
      end else if (bus.addr == oscr_pkg::ADDR_IR_AMP) begin
        next_s.ir_amplitude = bus.wdata; // R12
      end else if (bus.addr == oscr_pkg::ADDR_SLOT_LO) begin
        next_s.time_slot_sel[0] = bus.wdata[oscr_pkg::SLOT_ODD_LSB +: 3]; // R13
        next_s.time_slot_sel[1] = bus.wdata[oscr_pkg::SLOT_EVEN_LSB +: 3]; // R13
      end else if (bus.addr == oscr_pkg::ADDR_SLOT_HI) begin
        next_s.time_slot_sel[2] = bus.wdata[oscr_pkg::SLOT_ODD_LSB +: 3]; // R13
        next_s.time_slot_sel[3] = bus.wdata[oscr_pkg::SLOT_EVEN_LSB +: 3]; // R13
      end else if (bus.addr == oscr_pkg::ADDR_TEMP_TRIG) begin
        // A trigger while busy is absorbed into the running conversion unless its result lands in the same cycle
        if (bus.wdata[oscr_pkg::TEMP_TRIG_BIT] && !next_s.temp_busy) begin
          next_s.temp_busy = 1'b1; // R20
          next_s.temp_start = 1'b1; // R20
        end
      end
    end

    // Derived controls follow the registers they depend on
    next_s.acquire_en = !next_s.power_save_bit &&
                        (next_s.mode == oscr_pkg::MODE_HR ||
                         next_s.mode == oscr_pkg::MODE_OXI ||
                         next_s.mode == oscr_pkg::MODE_MULTI); // R1 R6
    next_s.irq_clear = next_s.power_save_bit; // R3
    next_s.full_scale = oscr_pkg::FULL_SCALE_BASE_NA << next_s.adc_range_sel; // R8
    next_s.rate_sps = oscr_pkg::rate_sps(next_s.sample_rate_sel); // R9
    next_s.pw_ns = oscr_pkg::pulse_ns(next_s.pulse_width_sel); // R11
    next_s.res_bits = oscr_pkg::RES_BASE_BITS + {3'h0, next_s.pulse_width_sel}; // R11
    next_s.red_ua = 16'(next_s.red_amplitude * oscr_pkg::AMP_STEP_UA); // R12
    next_s.ir_ua = 16'(next_s.ir_amplitude * oscr_pkg::AMP_STEP_UA); // R12

    next_s.red_mask = 4'h0;
    next_s.ir_mask = 4'h0;
    next_s.active_mask = 4'h0;
    if (next_s.mode == oscr_pkg::MODE_HR) begin
      next_s.red_mask = 4'h1; // R21
      next_s.active_mask = 4'h1; // R21
    end else if (next_s.mode == oscr_pkg::MODE_OXI) begin
      next_s.red_mask = 4'h1;
      next_s.ir_mask = 4'h2;
      next_s.active_mask = 4'h3;
    end else if (next_s.mode == oscr_pkg::MODE_MULTI) begin
      // Slots are taken as written; a gap before a later slot is the host's fault
      for (int i = 0; i < oscr_pkg::NUM_SLOTS; i++) begin
        next_s.red_mask[i] = next_s.time_slot_sel[i] == oscr_pkg::SLOT_RED; // R14
        next_s.ir_mask[i] = next_s.time_slot_sel[i] == oscr_pkg::SLOT_IR; // R14
        next_s.active_mask[i] = oscr_pkg::slot_active(next_s.time_slot_sel[i]); // R14 R16
      end
    end
    for (int i = 0; i < oscr_pkg::NUM_SLOTS; i++) begin
      n_active = n_active + {3'h0, next_s.active_mask[i]};
    end
    next_s.sample_bytes = 4'(n_active * oscr_pkg::BYTES_PER_SLOT); // R15
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '{por_pending: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign temp_start = s.temp_start;
  assign acquire_en = s.acquire_en;
  assign irq_clear = s.irq_clear;
  assign power_good_event = s.power_good_event; // R5
  assign active_mode = s.mode;
  assign adc_range_sel = s.adc_range_sel;
  assign adc_full_scale_na = s.full_scale;
  assign sample_rate_sel = s.sample_rate_sel;
  assign sample_rate_sps = s.rate_sps;
  assign pulse_width_sel = s.pulse_width_sel;
  assign pulse_width_ns = s.pw_ns;
  assign adc_resolution = s.res_bits;
  assign red_amplitude = s.red_amplitude;
  assign ir_amplitude = s.ir_amplitude;
  assign red_current_ua = s.red_ua;
  assign ir_current_ua = s.ir_ua;
  assign slot_red_mask = s.red_mask;
  assign slot_ir_mask = s.ir_mask;
  assign slot_active_mask = s.active_mask;
  assign sample_bytes = s.sample_bytes;

endmodule

// File: logic/oscr_pkg.sv
package oscr_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h09;
  localparam logic [7:0] ADDR_ACQ = 8'h0a;
  localparam logic [7:0] ADDR_RED_AMP = 8'h0c;
  localparam logic [7:0] ADDR_IR_AMP = 8'h0d;
  localparam logic [7:0] ADDR_SLOT_LO = 8'h11;
  localparam logic [7:0] ADDR_SLOT_HI = 8'h12;
  localparam logic [7:0] ADDR_TEMP_WHOLE = 8'h1f;
  localparam logic [7:0] ADDR_TEMP_PART = 8'h20;
  localparam logic [7:0] ADDR_TEMP_TRIG = 8'h21;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int POWER_SAVE_BIT = 7;
  localparam int SOFT_RST_BIT = 6;
  localparam int MODE_LSB = 0;
  localparam int ADC_RANGE_LSB = 5;
  localparam int RATE_LSB = 2;
  localparam int PW_LSB = 0;
  localparam int SLOT_ODD_LSB = 0;
  localparam int SLOT_EVEN_LSB = 4;
  localparam int TEMP_TRIG_BIT = 0;

  // Operating modes
  localparam logic [2:0] MODE_HR = 3'h2;
  localparam logic [2:0] MODE_OXI = 3'h3;
  localparam logic [2:0] MODE_MULTI = 3'h7;

  // Slot codes
  localparam logic [2:0] SLOT_OFF = 3'h0;
  localparam logic [2:0] SLOT_RED = 3'h1;
  localparam logic [2:0] SLOT_IR = 3'h2;
  localparam logic [2:0] SLOT_DARK_LAST = 3'h4;

  localparam logic [3:0] BYTES_PER_SLOT = 4'h3;
  localparam int NUM_SLOTS = 4;

  // Sample rate codes used as ceilings
  localparam logic [2:0] RATE_400 = 3'h3;
  localparam logic [2:0] RATE_800 = 3'h4;
  localparam logic [2:0] RATE_1000 = 3'h5;
  localparam logic [2:0] RATE_1600 = 3'h6;
  localparam logic [2:0] RATE_3200 = 3'h7;

  localparam logic [14:0] FULL_SCALE_BASE_NA = 15'h0800;
  localparam logic [4:0] RES_BASE_BITS = 5'h0f;
  localparam logic [15:0] AMP_STEP_UA = 16'h00c8;

  // Highest sample rate code the pulse width allows in a given mode
  function automatic logic [2:0] rate_ceiling(input logic [2:0] mode, input logic [1:0] pw);
    logic [2:0] r;
    r = RATE_3200;
    if (mode == MODE_HR) begin
      case (pw)
        2'h0: r = RATE_3200;
        2'h1: r = RATE_1600;
        2'h2: r = RATE_1000;
        default: r = RATE_800;
      endcase
    end else begin
      case (pw)
        2'h0: r = RATE_1600;
        2'h1: r = RATE_1000;
        2'h2: r = RATE_800;
        default: r = RATE_400;
      endcase
    end
    return r;
  endfunction

  function automatic logic [11:0] rate_sps(input logic [2:0] code);
    logic [11:0] v;
    case (code)
      3'h0: v = 12'h0032;
      3'h1: v = 12'h0064;
      3'h2: v = 12'h00c8;
      3'h3: v = 12'h0190;
      3'h4: v = 12'h0320;
      3'h5: v = 12'h03e8;
      3'h6: v = 12'h0640;
      default: v = 12'h0c80;
    endcase
    return v;
  endfunction

  // Pulse width in nanoseconds
  function automatic logic [18:0] pulse_ns(input logic [1:0] code);
    logic [18:0] v;
    case (code)
      2'h0: v = 19'h1_0d56;
      2'h1: v = 19'h1_cc14;
      2'h2: v = 19'h3_4990;
      default: v = 19'h6_447e;
    endcase
    return v;
  endfunction

  function automatic logic slot_active(input logic [2:0] code);
    return (code != SLOT_OFF) && (code <= SLOT_DARK_LAST);
  endfunction

endpackage

// File: logic/oscr_reg_if.sv
`timescale 1ns/1ps
interface oscr_reg_if;
  logic wr_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport master (
    output wr_stb,
    output addr,
    output wdata,
    input rdata
  );

  modport regs (
    input wr_stb,
    input addr,
    input wdata,
    output rdata
  );
endinterface

// File: logic/oscr_i2c_slave.sv
`timescale 1ns/1ps
module oscr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  oscr_reg_if.master bus
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_ADDR = 7'b000_0010,
    ST_ACK_ADDR = 7'b000_0100,
    ST_WR = 7'b000_1000,
    ST_ACK_WR = 7'b001_0000,
    ST_RD = 7'b010_0000,
    ST_ACK_RD = 7'b100_0000
  } oscr_i2c_st_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    oscr_i2c_st_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic drive;
    logic wr_stb;
    logic [7:0] wdata;
    logic level;
  } oscr_i2c_state_t;

  oscr_i2c_state_t s;
  oscr_i2c_state_t next_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign rise = s.scl_s2 & ~s.scl_d;
  assign fall = ~s.scl_s2 & s.scl_d;
  assign start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

  always_comb begin
    next_s = s;
    next_s.wr_stb = 1'b0;
    next_s.scl_s1 = scl_in;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d = s.sda_s2;
    // Pointer moves only after the strobe cycle so addr is stable with it
    if (s.wr_stb) begin
      next_s.ptr = s.ptr + 8'h01;
    end
    if (start) begin
      next_s.st = ST_ADDR;
      next_s.cnt = 4'h0;
      next_s.drive = 1'b0;
      next_s.first = 1'b1;
    end else if (stop) begin
      next_s.st = ST_IDLE;
      next_s.drive = 1'b0;
    end else begin
      case (s.st)
        ST_ADDR, ST_WR: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], s.sda_s2};
            next_s.cnt = s.cnt + 4'h1;
          end else if (fall && s.cnt == 4'h8) begin
            if (s.st == ST_ADDR) begin
              if (s.sh[7:1] == DEV_ADDR) begin
                next_s.drive = 1'b1;
                next_s.rw = s.sh[0];
                next_s.st = ST_ACK_ADDR;
              end else begin
                next_s.st = ST_IDLE;
              end
            end else begin
              next_s.drive = 1'b1;
              next_s.st = ST_ACK_WR;
              if (s.first) begin
                next_s.ptr = s.sh;
                next_s.first = 1'b0;
              end else begin
                next_s.wr_stb = 1'b1;
                next_s.wdata = s.sh;
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR, ST_ACK_RD: begin
          if (rise && s.st == ST_ACK_RD) begin
            next_s.nack = s.sda_s2;
          end
          if (fall) begin
            next_s.cnt = 4'h0;
            if (s.st == ST_ACK_WR || (s.st == ST_ACK_ADDR && !s.rw)) begin
              next_s.drive = 1'b0;
              next_s.st = ST_WR;
            end else if (s.st == ST_ACK_RD && s.nack) begin
              next_s.drive = 1'b0;
              next_s.st = ST_IDLE;
            end else begin
              next_s.sh = bus.rdata;
              next_s.drive = ~bus.rdata[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.st = ST_RD;
            end
          end
        end
        ST_RD: begin
          if (fall) begin
            next_s.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'h7) begin
              next_s.drive = 1'b0;
              next_s.st = ST_ACK_RD;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.drive = ~s.sh[6];
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '{st: ST_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
             sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = s.level;
  assign sda_oe_n = ~s.drive;
  assign bus.wr_stb = s.wr_stb;
  assign bus.addr = s.ptr;
  assign bus.wdata = s.wdata;

endmodule

// File: tb/oscr_host.sv
`timescale 1ns/1ps
module oscr_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic sys_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  // A released line reads high through the pull-up
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  ////////////////////////////////////////
  // START when c is 0, STOP when c is 1
  task automatic frame(input logic a, input logic c);
    tick(2);
    sda <= a;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda <= c;
    tick(4);
    scl <= c;
  endtask
  // Data moves a cycle after SCL falls, never in the same step
  task automatic xbit(input logic b, output logic r);
    tick(1);
    sda <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda_wire;
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
      q[i] = r;
    end
    xbit(1'b1, r);
    ack = !r;
  endtask
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    frame(1'b1, 1'b0);
    xbyte({DEV_ADDR, 1'b0}, q, k0);
    xbyte(a, q, k1);
    xbyte(d, q, k2);
    frame(1'b0, 1'b1);
    ok = k0 & k1 & k2;
  endtask
  // One byte only; the released ninth bit is the closing NACK
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
    logic k0, k1, k2, k3;
    frame(1'b1, 1'b0);
    xbyte({DEV_ADDR, 1'b0}, q, k0);
    xbyte(a, q, k1);
    frame(1'b1, 1'b0);
    xbyte({DEV_ADDR, 1'b1}, q, k2);
    xbyte(8'hff, q, k3);
    frame(1'b0, 1'b1);
    ok = k0 & k1 & k2 & !k3;
  endtask
endmodule

// File: tb/oscr_checker.sv
`timescale 1ns/1ps
module oscr_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic temp_start,
  input wire logic acquire_en,
  input wire logic irq_clear,
  input wire logic power_good_event,
  input wire logic [2:0] active_mode,
  input wire logic [1:0] adc_range_sel,
  input wire logic [14:0] adc_full_scale_na,
  input wire logic [1:0] pulse_width_sel,
  input wire logic [4:0] adc_resolution,
  input wire logic [3:0] slot_red_mask,
  input wire logic [3:0] slot_ir_mask,
  input wire logic [3:0] slot_active_mask,
  input wire logic [3:0] sample_bytes
);
  // Outputs hold reset zeros until the first edge, so checks wait one edge
  logic up;
  logic up_d;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up <= 1'b0;
      up_d <= 1'b0;
    end else begin
      up <= 1'b1;
      up_d <= up;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_event_once: assert property (power_good_event == (up && !up_d))
    else $error("power good event misplaced");
  chk_save_halts: assert property (irq_clear |-> !acquire_en)
    else $error("acquiring in power save");
  chk_mode_legal: assert property (acquire_en |-> active_mode inside {3'h2, 3'h3, 3'h7})
    else $error("acquiring in unused mode");
  chk_slot_bytes: assert property (up |-> sample_bytes == 4'($countones(slot_active_mask) * 3))
    else $error("sample length wrong");
  chk_hr_red: assert property (up && active_mode == 3'h2 |-> {slot_ir_mask, slot_red_mask} == 8'h01)
    else $error("heart rate mode not red only");
  chk_full_scale: assert property (up |-> adc_full_scale_na == 15'h0800 << adc_range_sel)
    else $error("full scale wrong");
  chk_res_bits: assert property (up |-> adc_resolution == 5'h0f + 5'(pulse_width_sel))
    else $error("resolution wrong");
  chk_temp_once: assert property (temp_start |=> !temp_start ##1 !temp_start)
    else $error("conversion start repeated");
endmodule

bind oscr_top oscr_checker u_chk (
  .sys_clk, .rst, .temp_start, .acquire_en, .irq_clear, .power_good_event, .active_mode,
  .adc_range_sel, .adc_full_scale_na, .pulse_width_sel, .adc_resolution, .slot_red_mask,
  .slot_ir_mask, .slot_active_mask, .sample_bytes
);

// File: tb/test_optical_sensor_control_regs.sv
`timescale 1ns/1ps
module test_optical_sensor_control_regs;
  logic sys_clk, rst, scl, sda_m, sda_out, sda_oe_n, temp_valid, temp_start;
  logic acquire_en, irq_clear, power_good_event;
  logic [2:0] active_mode, sample_rate_sel;
  logic [3:0] temp_part_in, slot_red_mask, slot_ir_mask, slot_active_mask, sample_bytes;
  logic [4:0] adc_resolution;
  logic [7:0] temp_whole_in, red_amplitude, ir_amplitude;
  logic [11:0] sample_rate_sps;
  logic [14:0] adc_full_scale_na;
  logic [15:0] red_current_ua, ir_current_ua;
  logic [18:0] pulse_width_ns;
  int errors, comparisons, starts, events;
  // Open drain: any party pulling low wins over the pull-up
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  oscr_top uut (
    .sys_clk, .rst, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe_n, .temp_valid,
    .temp_whole_in, .temp_part_in, .temp_start, .acquire_en, .irq_clear, .power_good_event,
    .active_mode, .adc_range_sel(), .adc_full_scale_na, .sample_rate_sel, .sample_rate_sps,
    .pulse_width_sel(), .pulse_width_ns, .adc_resolution, .red_amplitude, .ir_amplitude,
    .red_current_ua, .ir_current_ua, .slot_red_mask, .slot_ir_mask, .slot_active_mask,
    .sample_bytes
  );
  oscr_host host (.sys_clk, .sda_wire(sda_w), .scl, .sda(sda_m));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counted mid-cycle, away from the edge that updates them
  always @(negedge sys_clk) begin
    starts += (temp_start === 1'b1);
    events += (power_good_event === 1'b1);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wr(a, d, ok);
    chk(ok, 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    logic [7:0] q;
    host.rd(a, q, ok);
    chk({ok, q}, {1'b1, e});
  endtask
  task automatic end_sim;
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Every register plus the unmapped 0x0b reads zero
  task automatic t_zero;
    logic [7:0] r [10] = '{8'h09, 8'h0a, 8'h0c, 8'h0d, 8'h11, 8'h12, 8'h1f, 8'h20, 8'h21, 8'h0b};
    foreach (r[i]) rd(r[i], 8'h00);
    chk(events, 1);
  endtask
  task automatic t_modes;
    logic [2:0] m [3] = '{3'h2, 3'h3, 3'h7};
    logic [11:0] e [3] = '{12'h301, 12'h621, 12'h000};
    wr(8'h0a, 8'h27);
    for (int i = 0; i < 3; i++) begin
      wr(8'h09, {5'b00111, m[i]});
      rd(8'h09, {5'b00000, m[i]});
      chk({acquire_en, active_mode}, {1'b1, m[i]});
      chk({sample_bytes, slot_ir_mask, slot_red_mask}, e[i]);
      rd(8'h0a, 8'h27);
    end
  endtask
  task automatic t_acq;
    logic [2:0] cap [2][4] = '{'{3'h6, 3'h5, 3'h4, 3'h3}, '{3'h7, 3'h6, 3'h5, 3'h4}};
    int sps [8] = '{50, 100, 200, 400, 800, 1000, 1600, 3200};
    int ns [4] = '{68950, 117780, 215440, 410750};
    logic [2:0] c;
    for (int h = 0; h < 2; h++) begin
      wr(8'h09, h ? 8'h02 : 8'h03);
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < 2; s++) begin
          c = s ? cap[h][p] : 3'(p);
          wr(8'h0a, {1'b0, 2'(p), s ? 3'h7 : 3'(p), 2'(p)});
          rd(8'h0a, {1'b0, 2'(p), c, 2'(p)});
          chk({sample_rate_sel, sample_rate_sps}, {c, 12'(sps[c])});
          chk({pulse_width_ns, adc_resolution}, {19'(ns[p]), 5'(15 + p)});
          chk(adc_full_scale_na, 2048 << p);
        end
      end
    end
    wr(8'h09, 8'h03);
    rd(8'h0a, 8'h73);
  endtask
  task automatic t_slots;
    wr(8'h0c, 8'hff);
    wr(8'h0d, 8'h01);
    chk({red_current_ua, ir_current_ua}, 32'hc738_00c8);
    chk({red_amplitude, ir_amplitude}, 16'hff01);
    wr(8'h09, 8'h07);
    wr(8'h11, 8'h21);
    wr(8'h12, 8'h43);
    chk({slot_red_mask, slot_ir_mask, slot_active_mask}, 12'h12f);
    chk(sample_bytes, 4'hc);
    wr(8'h12, 8'h00);
    chk({slot_active_mask, sample_bytes}, 8'h36);
  endtask
  task automatic t_save;
    wr(8'h09, 8'h83);
    chk({acquire_en, irq_clear}, 2'b01);
    wr(8'h0d, 8'h10);
    rd(8'h0d, 8'h10);
    rd(8'h09, 8'h83);
    rd(8'h11, 8'h21);
    wr(8'h09, 8'h03);
    chk({acquire_en, irq_clear}, 2'b10);
  endtask
  task automatic t_temp;
    wr(8'h21, 8'h01);
    wr(8'h1f, 8'h55);
    rd(8'h1f, 8'h00);
    wr(8'h21, 8'h01);
    rd(8'h21, 8'h01);
    chk(starts, 1);
    temp_whole_in <= 8'h80;
    temp_part_in <= 4'h8;
    temp_valid <= 1'b1;
    @(posedge sys_clk);
    temp_valid <= 1'b0;
    rd(8'h1f, 8'h80);
    rd(8'h20, 8'h08);
    rd(8'h21, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    temp_valid = 1'b0;
    temp_whole_in = 8'h00;
    temp_part_in = 4'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    t_zero();
    t_modes();
    t_acq();
    t_slots();
    t_save();
    t_temp();
    wr(8'h09, 8'h43);
    t_zero();
    end_sim();
  end
  initial begin
    // Tests need about 26000 cycles; this leaves ample margin
    #600000;
    errors++;
    end_sim();
  end
endmodule
